/* File: design/eag_consts.svh */
// constants for the effective address generator
`ifndef EAG_CONSTS_SVH
`define EAG_CONSTS_SVH
`define EAG_PC_W 19
`define EAG_TGT_W 18
`define EAG_DADDR_W 16
`define EAG_SFR_BASE 16'h3F00
`define EAG_RAM_BASE 16'h0000
`endif

/* File: design/eag_ext.sv */
// sign and zero extension of instruction fields
module eag_ext
  import eag_pkg::*;
(
  eag_ext_if.server ext
);
  always_comb begin
    ext.sext = 18'h00000;
    ext.zext = 16'h0000;
    unique case (ext.width)
      EAG_W4: begin
        ext.sext = {{14{ext.raw[3]}}, ext.raw[3:0]};
        ext.zext = {12'h000, ext.raw[3:0]};
      end
      EAG_W7: begin
        ext.sext = {{11{ext.raw[6]}}, ext.raw[6:0]};
        ext.zext = {9'h000, ext.raw[6:0]};
      end
      EAG_W8: begin
        ext.sext = {{10{ext.raw[7]}}, ext.raw[7:0]};
        ext.zext = {8'h00, ext.raw[7:0]};
      end
      EAG_W11: begin
        ext.sext = {{7{ext.raw[10]}}, ext.raw[10:0]};
        ext.zext = {5'h00, ext.raw[10:0]};
      end
      EAG_W12: begin
        ext.sext = {{6{ext.raw[11]}}, ext.raw[11:0]};
        ext.zext = {4'h0, ext.raw[11:0]};
      end
      EAG_W16: begin
        ext.sext = {{2{ext.raw[15]}}, ext.raw};
        ext.zext = ext.raw;
      end
      default: begin
        ext.sext = 18'h00000;
        ext.zext = 16'h0000;
      end
    endcase
  end
endmodule

/* File: design/eag_ext_if.sv */
// displacement extension request and result
interface eag_ext_if;
  import eag_pkg::*;
  logic [15:0] raw;
  eag_width_t width;
  logic [17:0] sext;
  logic [15:0] zext;
  modport client (output raw, output width, input sext, input zext);
  modport server (input raw, input width, output sext, output zext);
endinterface

/* File: design/eag_pkg.sv */
// types for the effective address generator
package eag_pkg;
  typedef enum logic [3:0] {
    EAG_REG_DIRECT, EAG_IMMEDIATE, EAG_REG_IND, EAG_REG_REL8,
    EAG_REG_REL16, EAG_PC_REL, EAG_SP_REL, EAG_ABS, EAG_RAM_SHORT,
    EAG_IO_SHORT, EAG_HANDY, EAG_ABS18
  } eag_mode_t;
  typedef enum logic [2:0] {
    EAG_W4, EAG_W7, EAG_W8, EAG_W11, EAG_W12, EAG_W16
  } eag_width_t;
  typedef enum logic [1:0] {
    EAG_OP_ALU, EAG_OP_BYTE_COPY, EAG_OP_WORD_COPY, EAG_OP_BRANCH
  } eag_op_t;
  typedef enum logic [2:0] {
    EAG_SEL_DATA, EAG_SEL_PAIR, EAG_SEL_APTR, EAG_SEL_SP, EAG_SEL_FLAG
  } eag_regsel_t;
endpackage

/* File: design/eag_top.sv */
// effective address generator datapath
`include "eag_consts.svh"
module eag_top
  import eag_pkg::*;
#(
  parameter int DAW = `EAG_DADDR_W
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // request from decoder
  input wire logic req_valid,
  input wire eag_mode_t req_mode,
  input wire eag_width_t req_width,
  input wire eag_op_t req_op,
  input wire eag_regsel_t req_regsel,
  input wire logic [1:0] req_regnum,
  input wire logic [15:0] req_field,
  input wire logic req_word,
  // core register values
  input wire logic [15:0] addr_ptr_reg0,
  input wire logic [15:0] addr_ptr_reg1,
  input wire logic [15:0] stack_top_ptr,
  input wire logic [18:0] prog_counter,
  // data address result
  output logic mem_valid,
  output logic [DAW-1:0] mem_addr,
  output logic mem_word,
  output logic mem_second,
  // branch target
  output logic tgt_valid,
  output logic [18:0] tgt_addr,
  // operand result
  output logic opnd_valid,
  output logic [15:0] opnd_imm,
  output logic opnd_is_reg,
  output eag_regsel_t opnd_regsel,
  output logic [1:0] opnd_regnum,
  // illegal combination
  output logic mode_err
);
  eag_ext_if ext ();
  logic [15:0] reused_addr_r;
  logic [DAW-1:0] daddr;
  logic [15:0] ptr;
  logic [18:0] tgt;
  logic is_mem, is_tgt, is_opnd, illegal;
  logic word_pend_r;
  logic [DAW-1:0] word_addr_r;

  eag_ext u_ext (.ext(ext.server));

  assign ext.raw = req_field;
  assign ext.width = req_width;
  assign ptr = req_regnum[0] ? addr_ptr_reg1 : addr_ptr_reg0;

  // address formation
  always_comb begin
    daddr = '0;
    tgt = '0;
    is_mem = 1'b0;
    is_tgt = 1'b0;
    is_opnd = 1'b0;
    unique case (req_mode)
      EAG_REG_DIRECT, EAG_IMMEDIATE: is_opnd = 1'b1;
      EAG_REG_IND: begin
        daddr = DAW'(ptr);
        is_mem = 1'b1;
      end
      EAG_REG_REL8: begin
        // mode fixes the width, sign-extended
        daddr = DAW'(ptr + {{8{req_field[7]}}, req_field[7:0]});
        is_mem = 1'b1;
      end
      EAG_REG_REL16: begin
        daddr = DAW'(ptr + req_field);
        is_mem = 1'b1;
      end
      EAG_SP_REL: begin
        daddr = DAW'(stack_top_ptr + ext.sext[15:0]);
        is_mem = 1'b1;
      end
      EAG_ABS: begin
        daddr = DAW'(ext.zext);
        is_mem = 1'b1;
      end
      EAG_RAM_SHORT: begin
        daddr = DAW'(`EAG_RAM_BASE | {8'h00, req_field[7:0]});
        is_mem = 1'b1;
      end
      EAG_IO_SHORT: begin
        daddr = DAW'(`EAG_SFR_BASE + {8'h00, req_field[7:0]});
        is_mem = 1'b1;
      end
      EAG_HANDY: begin
        daddr = DAW'(reused_addr_r);
        is_mem = 1'b1;
      end
      EAG_PC_REL: begin
        // displacement counts nibbles, so it adds to the 19-bit pc
        tgt = prog_counter + {ext.sext[17], ext.sext};
        is_tgt = 1'b1;
      end
      EAG_ABS18: begin
        tgt = {2'h0, req_field, 1'b0};
        is_tgt = 1'b1;
      end
      default: ;
    endcase
  end

  // legality of mode against the instruction kind
  always_comb begin
    illegal = 1'b0;
    if (is_tgt && req_op != EAG_OP_BRANCH) illegal = 1'b1;
    if (req_mode == EAG_HANDY && req_op != EAG_OP_BYTE_COPY &&
        req_op != EAG_OP_WORD_COPY) illegal = 1'b1;
    if (is_mem && req_op == EAG_OP_ALU) illegal = 1'b1;
    if (req_mode == EAG_REG_DIRECT && req_regsel == EAG_SEL_FLAG &&
        req_regnum != 2'h0) illegal = 1'b1;
  end

  // reused address tracks every data access except a word's second beat
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reused_addr_r <= 16'h0000;
    end else if (clk_en && req_valid && is_mem && !illegal &&
                 !word_pend_r) begin
      reused_addr_r <= 16'(daddr);
    end
  end

  // word access split into two byte beats, any alignment
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      word_pend_r <= 1'b0;
      word_addr_r <= '0;
    end else if (clk_en) begin
      if (word_pend_r) begin
        word_pend_r <= 1'b0;
      end else if (req_valid && is_mem && !illegal && req_word) begin
        word_pend_r <= 1'b1;
        word_addr_r <= DAW'(daddr + DAW'(1));
      end
    end
  end

  // data address outputs
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_valid <= 1'b0;
      mem_addr <= '0;
      mem_word <= 1'b0;
      mem_second <= 1'b0;
    end else if (clk_en) begin
      if (word_pend_r) begin
        mem_valid <= 1'b1;
        mem_addr <= word_addr_r;
        mem_word <= 1'b1;
        mem_second <= 1'b1;
      end else begin
        mem_valid <= req_valid && is_mem && !illegal;
        mem_addr <= daddr;
        mem_word <= req_word;
        mem_second <= 1'b0;
      end
    end
  end

  // branch target outputs
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tgt_valid <= 1'b0;
      tgt_addr <= 19'h00000;
    end else if (clk_en) begin
      tgt_valid <= req_valid && is_tgt && !illegal && !word_pend_r;
      tgt_addr <= tgt;
    end
  end

  // operand outputs
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      opnd_valid <= 1'b0;
      opnd_imm <= 16'h0000;
      opnd_is_reg <= 1'b0;
      opnd_regsel <= EAG_SEL_DATA;
      opnd_regnum <= 2'h0;
      mode_err <= 1'b0;
    end else if (clk_en) begin
      opnd_valid <= req_valid && is_opnd && !illegal && !word_pend_r;
      opnd_imm <= ext.zext;
      opnd_is_reg <= req_mode == EAG_REG_DIRECT;
      opnd_regsel <= req_regsel;
      opnd_regnum <= req_regnum;
      mode_err <= req_valid && illegal && !word_pend_r;
    end
  end

  // checks
  a_indirect_addr: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && req_valid && req_mode == EAG_REG_IND && req_op != EAG_OP_ALU
    && !word_pend_r |=> mem_valid && mem_addr == $past(DAW'(ptr)))
    else $error("indirect address wrong");
  a_io_short: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && req_valid && req_mode == EAG_IO_SHORT && req_op != EAG_OP_ALU
    && !word_pend_r |=> mem_addr[15:8] == 8'h3F)
    else $error("io short base wrong");
  a_ram_short: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && req_valid && req_mode == EAG_RAM_SHORT && !word_pend_r
    |=> mem_addr[15:8] == 8'h00)
    else $error("ram short out of page");
  a_branch_only: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && req_valid && req_mode == EAG_PC_REL && req_op != EAG_OP_BRANCH
    && !word_pend_r |=> !tgt_valid && mode_err)
    else $error("pc relative outside branch");
  a_alu_no_mem: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    mem_valid && !mem_second && $past(clk_en)
    |-> $past(req_op) != EAG_OP_ALU)
    else $error("alu used memory mode");
  a_handy_reuse: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    mem_valid && !mem_second && !req_valid ##1 clk_en && req_valid
    && req_mode == EAG_HANDY && req_op != EAG_OP_ALU
    && req_op != EAG_OP_BRANCH && !word_pend_r
    |=> mem_addr == $past(mem_addr, 2))
    else $error("handy address not reused");
  a_word_split: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && mem_valid && mem_word && !mem_second
    |=> mem_valid && mem_second && mem_addr == DAW'($past(mem_addr) + 1))
    else $error("word second byte wrong");
  a_pc_rel_tgt: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && req_valid && req_mode == EAG_PC_REL && req_width == EAG_W4
    && req_op == EAG_OP_BRANCH && !word_pend_r
    |=> tgt_addr == 19'($past(prog_counter) + {{15{$past(req_field[3])}},
    $past(req_field[3:0])}))
    else $error("pc relative target wrong");
  a_reg_rel8: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && req_valid && req_mode == EAG_REG_REL8 && req_op != EAG_OP_ALU
    && !word_pend_r |=> mem_valid && 16'(mem_addr - $past(ptr)) ==
    {{8{$past(req_field[7])}}, $past(req_field[7:0])})
    else $error("short relative address wrong");
  a_reg_rel16: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && req_valid && req_mode == EAG_REG_REL16 && req_op != EAG_OP_ALU
    && !word_pend_r
    |=> mem_valid && mem_addr == DAW'($past(ptr) + $past(req_field)))
    else $error("long relative address wrong");
  a_stack_rel: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && req_valid && req_mode == EAG_SP_REL && req_width == EAG_W4
    && req_op != EAG_OP_ALU && !word_pend_r
    |=> mem_valid && 16'(mem_addr - $past(stack_top_ptr)) ==
    {{12{$past(req_field[3])}}, $past(req_field[3:0])})
    else $error("stack relative address wrong");
  a_abs18_tgt: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && req_valid && req_mode == EAG_ABS18 && req_op == EAG_OP_BRANCH
    && !word_pend_r
    |=> tgt_valid && tgt_addr == {2'h0, $past(req_field), 1'b0})
    else $error("long absolute target wrong");
  a_abs18_branch: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && req_valid && req_mode == EAG_ABS18 && req_op != EAG_OP_BRANCH
    && !word_pend_r |=> !tgt_valid && mode_err)
    else $error("long absolute outside branch");
  a_handy_copy: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && req_valid && req_mode == EAG_HANDY && !word_pend_r
    && (req_op == EAG_OP_ALU || req_op == EAG_OP_BRANCH)
    |=> !mem_valid && mode_err)
    else $error("handy used outside copy");
  a_flag_regnum: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && req_valid && req_mode == EAG_REG_DIRECT
    && req_regsel == EAG_SEL_FLAG && req_regnum != 2'h0 && !word_pend_r
    |=> !opnd_valid && mode_err)
    else $error("bad flag word select accepted");
  a_imm_value: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && req_valid && req_mode == EAG_IMMEDIATE && req_width == EAG_W4
    && !word_pend_r |=> opnd_valid && !opnd_is_reg
    && opnd_imm == {12'h000, $past(req_field[3:0])})
    else $error("immediate value wrong");
  a_refused_beat: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && word_pend_r |=> mem_valid && mem_second && !tgt_valid
    && !opnd_valid && !mode_err && $stable(reused_addr_r))
    else $error("request taken during second beat");
  a_reused_track: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && req_valid && is_mem && !illegal && !word_pend_r
    |=> reused_addr_r == 16'(mem_addr))
    else $error("reused address not updated");
  a_pc_rel_long: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && req_valid && req_mode == EAG_PC_REL && req_width == EAG_W16
    && req_op == EAG_OP_BRANCH && !word_pend_r
    |=> tgt_valid && tgt_addr == 19'($past(prog_counter)
    + {{3{$past(req_field[15])}}, $past(req_field)}))
    else $error("long pc relative target wrong");
endmodule

/* File: verif/eag_top_tb.sv */
// self-checking bench for the effective address generator
module eag_top_tb
  import eag_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  logic req_valid = 1'b0;
  eag_mode_t req_mode = EAG_REG_DIRECT;
  eag_width_t req_width = EAG_W8;
  eag_op_t req_op = EAG_OP_ALU;
  eag_regsel_t req_regsel = EAG_SEL_DATA;
  logic [1:0] req_regnum = 2'h0;
  logic [15:0] req_field = 16'h0000;
  logic req_word = 1'b0;
  logic [15:0] addr_ptr_reg0 = 16'h1235;
  logic [15:0] addr_ptr_reg1 = 16'h1000;
  logic [15:0] stack_top_ptr = 16'h0100;
  logic [18:0] prog_counter = 19'h00100;
  logic mem_valid, mem_word, mem_second, tgt_valid, opnd_valid;
  logic opnd_is_reg, mode_err;
  logic [15:0] mem_addr, opnd_imm;
  logic [18:0] tgt_addr;
  eag_regsel_t opnd_regsel;
  logic [1:0] opnd_regnum;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;

  eag_top i_eag_top (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en),
    .req_valid(req_valid), .req_mode(req_mode), .req_width(req_width),
    .req_op(req_op), .req_regsel(req_regsel), .req_regnum(req_regnum),
    .req_field(req_field), .req_word(req_word),
    .addr_ptr_reg0(addr_ptr_reg0), .addr_ptr_reg1(addr_ptr_reg1),
    .stack_top_ptr(stack_top_ptr), .prog_counter(prog_counter),
    .mem_valid(mem_valid), .mem_addr(mem_addr), .mem_word(mem_word),
    .mem_second(mem_second), .tgt_valid(tgt_valid), .tgt_addr(tgt_addr),
    .opnd_valid(opnd_valid), .opnd_imm(opnd_imm),
    .opnd_is_reg(opnd_is_reg), .opnd_regsel(opnd_regsel),
    .opnd_regnum(opnd_regnum), .mode_err(mode_err));

  always #10 core_clk = ~core_clk;

  task automatic stop_test();
    $display("tests %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // timeout guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      $display("unexpected at %0t: run timed out", $time);
      stop_test();
    end
  end

  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  // one request, answer visible on return
  task automatic issue(input eag_mode_t m, input eag_width_t w,
                       input eag_op_t o, input logic [15:0] f,
                       input logic wd);
    @(negedge core_clk);
    req_valid = 1'b1;
    req_mode = m;
    req_width = w;
    req_op = o;
    req_field = f;
    req_word = wd;
    @(negedge core_clk);
    req_valid = 1'b0;
  endtask

  task automatic mem_chk(input logic [15:0] a, input logic s);
    chk(mem_valid === 1'b1 && mem_addr === a && mem_second === s,
        "data address");
  endtask

  task automatic err_chk();
    chk(mode_err === 1'b1 && mem_valid === 1'b0 && tgt_valid === 1'b0,
        "illegal combination");
  endtask

  task automatic t_word();
    issue(EAG_REG_IND, EAG_W16, EAG_OP_WORD_COPY, 16'h0000, 1'b1);
    mem_chk(16'h1235, 1'b0);
    chk(mem_word === 1'b1, "word flag");
    @(negedge core_clk);
    mem_chk(16'h1236, 1'b1);
    @(negedge core_clk);
    chk(mem_valid === 1'b0, "third beat");
    $display("word transfer done");
  endtask

  task automatic t_rel();
    req_regnum = 2'h1;
    issue(EAG_REG_REL8, EAG_W8, EAG_OP_BYTE_COPY, 16'h00F0, 1'b0);
    mem_chk(16'h0FF0, 1'b0);
    req_regnum = 2'h0;
    issue(EAG_REG_REL16, EAG_W16, EAG_OP_BYTE_COPY, 16'h1234, 1'b0);
    mem_chk(16'h2469, 1'b0);
    issue(EAG_SP_REL, EAG_W4, EAG_OP_BYTE_COPY, 16'h000F, 1'b0);
    mem_chk(16'h00FF, 1'b0);
    issue(EAG_SP_REL, EAG_W8, EAG_OP_BYTE_COPY, 16'h0010, 1'b0);
    mem_chk(16'h0110, 1'b0);
    issue(EAG_SP_REL, EAG_W16, EAG_OP_BYTE_COPY, 16'hFFFE, 1'b0);
    mem_chk(16'h00FE, 1'b0);
    $display("relative modes done");
  endtask

  task automatic t_short();
    issue(EAG_RAM_SHORT, EAG_W8, EAG_OP_BYTE_COPY, 16'h0042, 1'b0);
    mem_chk(16'h0042, 1'b0);
    issue(EAG_IO_SHORT, EAG_W8, EAG_OP_BYTE_COPY, 16'h0042, 1'b0);
    mem_chk(16'h3F42, 1'b0);
    issue(EAG_HANDY, EAG_W8, EAG_OP_WORD_COPY, 16'h0000, 1'b0);
    mem_chk(16'h3F42, 1'b0);
    issue(EAG_HANDY, EAG_W8, EAG_OP_ALU, 16'h0000, 1'b0);
    err_chk();
    issue(EAG_REG_IND, EAG_W8, EAG_OP_ALU, 16'h0000, 1'b0);
    err_chk();
    $display("short and handy modes done");
  endtask

  task automatic t_abs();
    issue(EAG_ABS, EAG_W8, EAG_OP_BYTE_COPY, 16'h1234, 1'b0);
    mem_chk(16'h0034, 1'b0);
    issue(EAG_ABS, EAG_W12, EAG_OP_BYTE_COPY, 16'h1234, 1'b0);
    mem_chk(16'h0234, 1'b0);
    issue(EAG_ABS, EAG_W16, EAG_OP_BYTE_COPY, 16'h1234, 1'b0);
    mem_chk(16'h1234, 1'b0);
    $display("absolute modes done");
  endtask

  task automatic t_branch();
    issue(EAG_PC_REL, EAG_W4, EAG_OP_BRANCH, 16'h000F, 1'b0);
    chk(tgt_valid === 1'b1 && tgt_addr === 19'h000FF, "d4");
    issue(EAG_PC_REL, EAG_W7, EAG_OP_BRANCH, 16'h0003, 1'b0);
    chk(tgt_valid === 1'b1 && tgt_addr === 19'h00103, "d7");
    issue(EAG_PC_REL, EAG_W16, EAG_OP_BRANCH, 16'h0010, 1'b0);
    chk(tgt_valid === 1'b1 && tgt_addr === 19'h00110, "d16");
    issue(EAG_ABS18, EAG_W16, EAG_OP_BRANCH, 16'h1234, 1'b0);
    chk(tgt_valid === 1'b1 && tgt_addr === 19'h02468, "abs18");
    issue(EAG_PC_REL, EAG_W4, EAG_OP_BYTE_COPY, 16'h0001, 1'b0);
    err_chk();
    issue(EAG_ABS18, EAG_W16, EAG_OP_BYTE_COPY, 16'h1234, 1'b0);
    err_chk();
    $display("branch targets done");
  endtask

  task automatic t_opnd();
    issue(EAG_IMMEDIATE, EAG_W4, EAG_OP_ALU, 16'h00F7, 1'b0);
    chk(opnd_valid === 1'b1 && opnd_imm === 16'h0007, "imm4");
    issue(EAG_IMMEDIATE, EAG_W16, EAG_OP_ALU, 16'hBEEF, 1'b0);
    chk(opnd_imm === 16'hBEEF && opnd_is_reg === 1'b0, "imm16");
    req_regsel = EAG_SEL_APTR;
    req_regnum = 2'h1;
    issue(EAG_REG_DIRECT, EAG_W8, EAG_OP_ALU, 16'h0000, 1'b0);
    chk(opnd_is_reg === 1'b1 && opnd_regsel === EAG_SEL_APTR
        && opnd_regnum === 2'h1, "reg direct");
    req_regsel = EAG_SEL_FLAG;
    issue(EAG_REG_DIRECT, EAG_W8, EAG_OP_ALU, 16'h0000, 1'b0);
    err_chk();
    $display("operand modes done");
  endtask

  task automatic t_hold();
    issue(EAG_RAM_SHORT, EAG_W8, EAG_OP_BYTE_COPY, 16'h0055, 1'b0);
    clk_en = 1'b0;
    repeat (2) @(negedge core_clk);
    mem_chk(16'h0055, 1'b0);
    req_valid = 1'b1;
    req_mode = EAG_IO_SHORT;
    req_field = 16'h0011;
    @(negedge core_clk);
    mem_chk(16'h0055, 1'b0);
    clk_en = 1'b1;
    req_valid = 1'b0;
    @(negedge core_clk);
    chk(mem_valid === 1'b0 && mode_err === 1'b0, "dropped");
    issue(EAG_HANDY, EAG_W8, EAG_OP_BYTE_COPY, 16'h0000, 1'b0);
    mem_chk(16'h0055, 1'b0);
    $display("clock enable hold done");
  endtask

  task automatic t_refuse();
    @(negedge core_clk);
    req_valid = 1'b1;
    req_mode = EAG_REG_IND;
    req_width = EAG_W16;
    req_op = EAG_OP_WORD_COPY;
    req_regnum = 2'h0;
    req_field = 16'h0000;
    req_word = 1'b1;
    @(negedge core_clk);
    mem_chk(16'h1235, 1'b0);
    req_mode = EAG_RAM_SHORT;
    req_op = EAG_OP_BYTE_COPY;
    req_field = 16'h0077;
    req_word = 1'b0;
    @(negedge core_clk);
    mem_chk(16'h1236, 1'b1);
    req_valid = 1'b0;
    @(negedge core_clk);
    chk(mem_valid === 1'b0 && mode_err === 1'b0, "second beat");
    issue(EAG_HANDY, EAG_W8, EAG_OP_BYTE_COPY, 16'h0000, 1'b0);
    mem_chk(16'h1235, 1'b0);
    $display("refused request done");
  endtask

  task automatic t_reset();
    issue(EAG_ABS, EAG_W16, EAG_OP_BYTE_COPY, 16'h4321, 1'b0);
    rst_b = 1'b0;
    #1;
    chk(mem_valid === 1'b0 && mem_addr === 16'h0000 && tgt_valid === 1'b0
        && opnd_valid === 1'b0 && mode_err === 1'b0, "async reset");
    @(negedge core_clk);
    rst_b = 1'b1;
    issue(EAG_HANDY, EAG_W8, EAG_OP_BYTE_COPY, 16'h0000, 1'b0);
    mem_chk(16'h0000, 1'b0);
    $display("mid-run reset done");
  endtask

  initial begin
    repeat (10) @(negedge core_clk);
    rst_b = 1'b1;
    chk(mem_valid === 1'b0 && tgt_valid === 1'b0 && opnd_valid === 1'b0
        && mode_err === 1'b0, "reset state");
    t_word();
    t_rel();
    t_short();
    t_abs();
    t_hold();
    t_refuse();
    t_branch();
    t_opnd();
    t_reset();
    stop_test();
  end
endmodule
